// ==== hw/sys_pkg.sv ====
package sys_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] BREAK_STATUS_IDX = 16'hfe00;
  localparam logic [15:0] RESET_CAUSE_IDX = 16'hfe01;
  localparam logic [15:0] BREAK_FLAG_CONTROL_IDX = 16'hfe03;
  localparam int ADDR_W = 18;
  localparam logic [17:0] BREAK_STATUS_ADDR = {BREAK_STATUS_IDX, 2'h0};
  localparam logic [17:0] RESET_CAUSE_ADDR = {RESET_CAUSE_IDX, 2'h0};
  localparam logic [17:0] BREAK_FLAG_CONTROL_ADDR = {BREAK_FLAG_CONTROL_IDX, 2'h0};

  // Field positions
  localparam int BREAK_WAIT_BIT = 1;
  localparam int CLEAR_ENABLE_BIT = 7;
  localparam int POR_BIT = 7;
  localparam int PIN_BIT = 6;
  localparam int WATCHDOG_BIT = 5;
  localparam int ILLEGAL_OPCODE_BIT = 4;
  localparam int ILLEGAL_ADDRESS_BIT = 3;
  localparam int USB_BIT = 2;
  localparam int LOW_VOLTAGE_BIT = 1;

  // Reset values
  localparam logic [7:0] RESET_CAUSE_POR = 8'h80;
  localparam logic [7:0] BREAK_STATUS_RESET = 8'h00;

  // Counts in crystal reference cycles
  localparam logic [12:0] STOP_RECOVERY_LONG = 13'h1000;
  localparam logic [12:0] STOP_RECOVERY_SHORT = 13'h0020;
  localparam logic [5:0] PIN_SAMPLE_DELAY = 6'h20;
  localparam logic [5:0] INT_RESET_HOLD = 6'h20;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP, MODE_RECOVER} mode_t;
  typedef enum logic [1:0] {RSEQ_IDLE, RSEQ_DRIVE, RSEQ_SETTLE} reset_seq_t;
endpackage

// ==== hw/sys_break_lowpower_reset.sv ====
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
// Functional notes
// - All reset sources share one top priority, above interrupts, never arbitrated.
// - Break output puts CPU in break state by forcing the software-interrupt vector.
// - In break with clear enable off, peripheral flag clearing is blocked.
// - Flags cleared in break with clearing enabled stay cleared afterwards.
// - Two-step clears stay protected in break; second step after exit clears.
// - Wait or stop clears the CPU interrupt mask and stops CPU clocks.
// - Wait mode gates CPU clocks off, peripheral clocks keep running.
// - Enabled interrupt wakes wait; stacking starts one cycle later.
// - Reset or break ends wait; break sets the break-wait flag.
// - Watchdog disable option at 0 keeps watchdog enabled, also in wait.
// - Stop resets recovery counter and disables clock generator output.
// - Interrupt, reset or break ends stop; interrupt stacks after recovery.
// - Recovery lasts 4096 crystal cycles, or 32 with short recovery set.
// - Recovery counter held reset from stop until recovery, then times it.
// - Three registers sit at three fixed bus addresses.
// - Reading reset cause clears it; power-on sets only its own flag.
// - Drive reset pin low in internal reset; sample it 32 cycles after release.
// - Reset cause holds power-on, pin, watchdog, opcode, address, USB, low-voltage.
// - Clear enable bit set permits flag clearing in break; clear blocks it.
// - External reset leaves the recovery counter free-running.
module sys_break_lowpower_reset (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic crystal_ref_clock,
  input wire logic break_request,
  input wire logic break_done,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic module_irq,
  input wire logic short_stop_recovery,
  input wire logic watchdog_disable_option,
  input wire logic watchdog_timeout,
  input wire logic illegal_opcode,
  input wire logic illegal_address,
  input wire logic usb_reset,
  input wire logic low_voltage,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic system_reset,
  output logic force_swi_vector,
  output logic break_active,
  output logic clear_permit,
  output logic irq_mask_clear,
  output logic stack_start,
  output logic cpu_clock_enable,
  output logic periph_clock_enable,
  output logic clock_gen_output,
  output logic watchdog_enable
);
  sys_pkg::mode_t mode;
  sys_pkg::reset_seq_t rseq;
  logic xtal_s1, xtal_s2, xtal_s3, xtal_tick;
  logic pin_s1, pin_s2, pin_low;
  logic [12:0] xtal_count, recovery_target;
  logic [5:0] rseq_count;
  logic wake_by_irq, int_reset_event, ext_reset_event, any_reset;
  logic [7:0] break_status, reset_cause, break_flag_control;
  logic aw_held, w_held;
  logic [17:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0, wr_fire, rd_fire, rd_cause;

  function automatic logic mapped(input logic [17:0] a);
    mapped = (a == sys_pkg::BREAK_STATUS_ADDR) || (a == sys_pkg::RESET_CAUSE_ADDR) ||
             (a == sys_pkg::BREAK_FLAG_CONTROL_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the crystal reference and the reset pin
  always_ff @(posedge ref_clk) begin
    xtal_s1 <= crystal_ref_clock;
    xtal_s2 <= xtal_s1;
    xtal_s3 <= xtal_s2;
    pin_s1 <= reset_pin_in;
    pin_s2 <= pin_s1;
  end

  // Rising edge of the crystal clock; it must be well below half of ref_clk
  assign xtal_tick = xtal_s2 & ~xtal_s3;
  assign pin_low = ~pin_s2;

  // Internal sources combine with no ordering among them
  assign int_reset_event = watchdog_timeout | illegal_opcode | illegal_address |
                           usb_reset | low_voltage;
  // The pin reads low while we drive it, so only an undriven low counts
  assign ext_reset_event = pin_low & (rseq == sys_pkg::RSEQ_IDLE);
  assign any_reset = int_reset_event | ext_reset_event;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin sequence: drive low, release, then sample after the delay
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rseq <= sys_pkg::RSEQ_DRIVE;
      rseq_count <= 6'h00;
    end else if (int_reset_event) begin
      rseq <= sys_pkg::RSEQ_DRIVE;
      rseq_count <= 6'h00;
    end else begin
      unique case (rseq)
        sys_pkg::RSEQ_IDLE: rseq_count <= 6'h00;
        sys_pkg::RSEQ_DRIVE: begin
          if (xtal_tick && rseq_count == sys_pkg::INT_RESET_HOLD - 6'h01) begin
            rseq <= sys_pkg::RSEQ_SETTLE;
            rseq_count <= 6'h00;
          end else if (xtal_tick) begin
            rseq_count <= rseq_count + 6'h01;
          end
        end
        sys_pkg::RSEQ_SETTLE: begin
          if (xtal_tick && rseq_count == sys_pkg::PIN_SAMPLE_DELAY - 6'h01) begin
            rseq <= sys_pkg::RSEQ_IDLE;
          end else if (xtal_tick) begin
            rseq_count <= rseq_count + 6'h01;
          end
        end
      endcase
    end
  end

  // Open-drain pin: enable low means we pull it low
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reset_pin_oe <= 1'b0;
      system_reset <= 1'b1;
    end else begin
      reset_pin_oe <= ~(int_reset_event | (rseq == sys_pkg::RSEQ_DRIVE));
      system_reset <= any_reset | (rseq != sys_pkg::RSEQ_IDLE);
    end
  end
  assign reset_pin_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Recovery counter: free after resets, held at zero through stop
  assign recovery_target = short_stop_recovery ? sys_pkg::STOP_RECOVERY_SHORT
                                               : sys_pkg::STOP_RECOVERY_LONG;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      xtal_count <= 13'h0000;
    end else if (mode == sys_pkg::MODE_STOP) begin
      xtal_count <= 13'h0000;
    end else if (xtal_tick) begin
      xtal_count <= xtal_count + 13'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power mode sequencer; any reset returns straight to run
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode <= sys_pkg::MODE_RUN;
      wake_by_irq <= 1'b0;
    end else if (any_reset) begin
      mode <= sys_pkg::MODE_RUN;
      wake_by_irq <= 1'b0;
    end else begin
      unique case (mode)
        sys_pkg::MODE_RUN: begin
          if (stop_exec) begin
            mode <= sys_pkg::MODE_STOP;
          end else if (wait_exec) begin
            mode <= sys_pkg::MODE_WAIT;
          end
        end
        sys_pkg::MODE_WAIT: begin
          if (module_irq || break_request) begin
            mode <= sys_pkg::MODE_RUN;
          end
        end
        sys_pkg::MODE_STOP: begin
          if (module_irq || break_request) begin
            mode <= sys_pkg::MODE_RECOVER;
            wake_by_irq <= module_irq & ~break_request;
          end
        end
        sys_pkg::MODE_RECOVER: begin
          if (xtal_count >= recovery_target) begin
            mode <= sys_pkg::MODE_RUN;
          end
        end
      endcase
    end
  end

  // Stacking pulse: one cycle after an interrupt wakes wait, or at the end of an interrupt-woken recovery
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stack_start <= 1'b0;
      irq_mask_clear <= 1'b0;
    end else begin
      stack_start <= ~any_reset & (((mode == sys_pkg::MODE_WAIT) & module_irq & ~break_request) |
                     ((mode == sys_pkg::MODE_RECOVER) & wake_by_irq &
                      (xtal_count >= recovery_target)));
      irq_mask_clear <= (mode == sys_pkg::MODE_RUN) & (wait_exec | stop_exec);
    end
  end

  // Clock gating follows the mode
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cpu_clock_enable <= 1'b1;
      periph_clock_enable <= 1'b1;
      clock_gen_output <= 1'b1;
      watchdog_enable <= 1'b0;
    end else begin
      cpu_clock_enable <= (mode == sys_pkg::MODE_RUN);
      periph_clock_enable <= (mode == sys_pkg::MODE_RUN) || (mode == sys_pkg::MODE_WAIT);
      clock_gen_output <= (mode == sys_pkg::MODE_RUN) || (mode == sys_pkg::MODE_WAIT);
      watchdog_enable <= ~watchdog_disable_option;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break state and flag protection
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      break_active <= 1'b0;
      force_swi_vector <= 1'b0;
      clear_permit <= 1'b1;
    end else begin
      if (any_reset || break_done) begin
        break_active <= 1'b0;
      end else if (break_request) begin
        break_active <= 1'b1;
      end
      force_swi_vector <= break_request & ~break_active & ~any_reset;
      // Peripherals gate both steps of their clears with this, so a step
      // taken before break cannot complete inside it
      clear_permit <= ~break_active |
                      break_flag_control[sys_pkg::CLEAR_ENABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data may arrive in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_cause = rd_fire & (s_axi_araddr == sys_pkg::RESET_CAUSE_ADDR);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 18'h00000;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sys_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? sys_pkg::RESP_OKAY : sys_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= sys_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? sys_pkg::RESP_OKAY : sys_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        sys_pkg::BREAK_STATUS_ADDR: s_axi_rdata <= {24'h000000, break_status};
        sys_pkg::RESET_CAUSE_ADDR: s_axi_rdata <= {24'h000000, reset_cause};
        sys_pkg::BREAK_FLAG_CONTROL_ADDR: s_axi_rdata <= {24'h000000, break_flag_control};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; hardware set wins over software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      break_status <= sys_pkg::BREAK_STATUS_RESET;
    end else if ((mode == sys_pkg::MODE_WAIT) && break_request && !any_reset) begin
      break_status[sys_pkg::BREAK_WAIT_BIT] <= 1'b1;
    end else if (wr_fire && w_lane0 && aw_addr == sys_pkg::BREAK_STATUS_ADDR &&
                 !w_data[sys_pkg::BREAK_WAIT_BIT]) begin
      break_status[sys_pkg::BREAK_WAIT_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      break_flag_control <= 8'h00;
    end else if (wr_fire && w_lane0 && aw_addr == sys_pkg::BREAK_FLAG_CONTROL_ADDR) begin
      break_flag_control[sys_pkg::CLEAR_ENABLE_BIT] <= w_data[sys_pkg::CLEAR_ENABLE_BIT];
    end
  end

  // Causes accumulate until read; the pin flag also catches a late low sample
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reset_cause <= sys_pkg::RESET_CAUSE_POR;
    end else begin
      reset_cause <= (rd_cause ? 8'h00 : reset_cause) | {1'b0,
        ext_reset_event | ((rseq == sys_pkg::RSEQ_SETTLE) & xtal_tick & pin_low &
          (rseq_count == sys_pkg::PIN_SAMPLE_DELAY - 6'h01)),
        watchdog_timeout, illegal_opcode, illegal_address, usb_reset, low_voltage,
        1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_wait_stack;
    (mode == sys_pkg::MODE_WAIT && module_irq && !break_request && !any_reset) |=> stack_start;
  endproperty
  a_wait_stack: assert property (p_wait_stack) else $error("No stacking after wake");

  property p_mask_clear;
    (mode == sys_pkg::MODE_RUN && wait_exec && !any_reset)
      |=> irq_mask_clear ##1 !cpu_clock_enable;
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("Wait did not clear mask");

  property p_wait_clocks;
    $past(mode == sys_pkg::MODE_WAIT) |-> !cpu_clock_enable && periph_clock_enable;
  endproperty
  a_wait_clocks: assert property (p_wait_clocks) else $error("Wrong clocks in wait");

  property p_stop_clocks;
    (mode == sys_pkg::MODE_STOP) |=> !clock_gen_output && !periph_clock_enable;
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("Clocks running in stop");

  property p_stop_count;
    (mode == sys_pkg::MODE_STOP) ##1 (mode == sys_pkg::MODE_RECOVER) |-> xtal_count <= 13'h0001;
  endproperty
  a_stop_count: assert property (p_stop_count) else $error("Counter not held in stop");

  property p_recover_len;
    (mode == sys_pkg::MODE_RECOVER && xtal_count < recovery_target && !any_reset)
      |=> mode == sys_pkg::MODE_RECOVER;
  endproperty
  a_recover_len: assert property (p_recover_len) else $error("Recovery ended early");

  property p_cause_read;
    (rd_cause && !any_reset && rseq == sys_pkg::RSEQ_IDLE) |=> reset_cause == 8'h00;
  endproperty
  a_cause_read: assert property (p_cause_read) else $error("Reset cause not cleared");

  property p_break_wait;
    (mode == sys_pkg::MODE_WAIT && break_request && !any_reset)
      |=> break_status[sys_pkg::BREAK_WAIT_BIT] ##1 break_status[sys_pkg::BREAK_WAIT_BIT];
  endproperty
  a_break_wait: assert property (p_break_wait) else $error("Break-wait flag not set");

  property p_permit;
    (break_active && !break_flag_control[sys_pkg::CLEAR_ENABLE_BIT]) |=> !clear_permit;
  endproperty
  a_permit: assert property (p_permit) else $error("Clearing allowed in break");

  property p_pin_drive;
    int_reset_event |=> !reset_pin_oe [*2];
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("Pin not driven in reset");

  property p_swi;
    (break_request && !break_active && !any_reset) |=> force_swi_vector && break_active;
  endproperty
  a_swi: assert property (p_swi) else $error("Break did not force vector");
endmodule

// ==== tb/periph_flag_model.sv ====
`timescale 1ns/100ps
// Stand-in for one peripheral status flag and the board reset wire
module periph_flag_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clear_permit,
  input wire logic set_flag,
  input wire logic step_one,
  input wire logic step_two,
  input wire logic reset_pin_oe,
  input wire logic reset_pin_out,
  input wire logic ext_reset_low,
  output logic flag,
  output logic pin_level
);
  logic armed;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-step clear: first access arms, second clears; the arm survives break
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flag <= 1'b0;
      armed <= 1'b0;
    end else if (set_flag) begin
      flag <= 1'b1;
    end else if (step_two && armed && clear_permit) begin
      flag <= 1'b0;
      armed <= 1'b0;
    end else if (step_one && flag && clear_permit) begin
      armed <= 1'b1;
    end
  end

  // Open drain with pull-up, so a released pin reads high, never the last value
  assign pin_level = (reset_pin_oe ? 1'b1 : reset_pin_out) & ~ext_reset_low;
endmodule

// ==== tb/sys_break_lowpower_reset_bench.sv ====
`timescale 1ns/100ps
module sys_break_lowpower_reset_bench;
  localparam int BRK = 0, DONE = 1, WT = 2, STP = 3, SETF = 4, S1 = 5, S2 = 6, XT = 6;
  logic ref_clk, resetn, crystal_ref_clock, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, module_irq, short_stop_recovery, watchdog_disable_option;
  logic reset_pin_out, reset_pin_oe, system_reset, force_swi_vector, break_active;
  logic clear_permit, irq_mask_clear, stack_start, cpu_clock_enable, periph_clock_enable;
  logic clock_gen_output, watchdog_enable, ext_reset_low, flag, pin_level;
  logic [12:0] pls;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int miscompares, n_checks, cycles, n;

  sys_break_lowpower_reset u_sys_break_lowpower_reset (
    .ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .crystal_ref_clock, .break_request(pls[0]), .break_done(pls[1]),
    .wait_exec(pls[2]), .stop_exec(pls[3]), .module_irq, .short_stop_recovery,
    .watchdog_disable_option, .watchdog_timeout(pls[12]), .illegal_opcode(pls[11]),
    .illegal_address(pls[10]), .usb_reset(pls[9]), .low_voltage(pls[8]),
    .reset_pin_in(pin_level), .reset_pin_out, .reset_pin_oe, .system_reset, .force_swi_vector,
    .break_active, .clear_permit, .irq_mask_clear, .stack_start, .cpu_clock_enable,
    .periph_clock_enable, .clock_gen_output, .watchdog_enable);

  periph_flag_model u_periph_flag_model (
    .ref_clk, .resetn, .clear_permit, .set_flag(pls[4]), .step_one(pls[5]),
    .step_two(pls[6]), .reset_pin_oe, .reset_pin_out, .ext_reset_low, .flag, .pin_level);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus clock, and a crystal slow enough for the two-flop synchroniser
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    crystal_ref_clock = 1'b0;
    #3;
    forever #24 crystal_ref_clock = ~crystal_ref_clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // Strobe ends with a spare edge so no signal is driven twice in one step
  task automatic pulse(input int b);
    pls[b] <= 1'b1;
    tick(1);
    pls[b] <= 1'b0;
    tick(1);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return system_reset;
      1: return stack_start;
      default: return reset_pin_oe;
    endcase
  endfunction
  task automatic await(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic cmp_range(input int got, input int lo, input int hi, input string what);
    n_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("unexpected at %0t: %s took %0d", $time, what, got);
    end
  endtask
  // Valids and payload held until their own ready edge
  task automatic axi_write(input logic [17:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic axi_read(input logic [17:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_map;
    cmp_bit(reset_pin_oe, 1'b0, "pin driven after power-on");
    await(0, 1'b0, 2000);
    cmp_bit(reset_pin_oe, 1'b1, "pin released");
    axi_read(sys_pkg::RESET_CAUSE_ADDR);
    cmp_word(rd, 32'h80, "power-on cause");
    axi_read(sys_pkg::RESET_CAUSE_ADDR);
    cmp_word(rd, 32'h0, "cause after read");
    axi_read(sys_pkg::BREAK_FLAG_CONTROL_ADDR);
    cmp_word(rd, 32'h0, "clear enable at reset");
    axi_read(18'h00010);
    cmp_word({30'h0, rsp}, 32'h2, "unmapped read");
    axi_write(18'h3f808, 32'h80);
    cmp_word({30'h0, rsp}, 32'h2, "unmapped write");
  endtask
  // Flag armed before break must survive break with clearing blocked
  task automatic t_break;
    pulse(SETF);
    pulse(S1);
    pulse(BRK);
    cmp_bit(force_swi_vector, 1'b1, "vector forced");
    tick(1);
    cmp_bit(break_active, 1'b1, "in break");
    cmp_bit(clear_permit, 1'b0, "permit withdrawn");
    pulse(S2);
    cmp_bit(flag, 1'b1, "second step in break");
    pulse(S1);
    pulse(S2);
    cmp_bit(flag, 1'b1, "flag kept in break");
    pulse(DONE);
    tick(1);
    cmp_bit(clear_permit, 1'b1, "permit after break");
    pulse(S2);
    cmp_bit(flag, 1'b0, "second step after break");
  endtask
  task automatic t_break_flag_clear_enable;
    axi_write(sys_pkg::BREAK_FLAG_CONTROL_ADDR, 32'h80);
    cmp_word({30'h0, rsp}, 32'h0, "write okay");
    axi_read(sys_pkg::BREAK_FLAG_CONTROL_ADDR);
    cmp_word(rd, 32'h80, "clear enable set");
    pulse(SETF);
    pulse(BRK);
    tick(1);
    cmp_bit(clear_permit, 1'b1, "permit with enable");
    pulse(S1);
    pulse(S2);
    pulse(DONE);
    tick(2);
    cmp_bit(flag, 1'b0, "cleared in break stays clear");
    axi_write(sys_pkg::BREAK_FLAG_CONTROL_ADDR, 32'h0);
  endtask
  task automatic t_wait;
    pulse(WT);
    cmp_bit(irq_mask_clear, 1'b1, "mask cleared by wait");
    tick(1);
    cmp_bit(cpu_clock_enable, 1'b0, "cpu clock off");
    cmp_bit(periph_clock_enable, 1'b1, "peripheral clock on");
    cmp_bit(watchdog_enable, 1'b1, "watchdog in wait");
    module_irq <= 1'b1;
    tick(1);
    cmp_bit(stack_start, 1'b0, "stacking too early");
    tick(1);
    cmp_bit(stack_start, 1'b1, "stacking one cycle on");
    module_irq <= 1'b0;
    axi_read(sys_pkg::BREAK_STATUS_ADDR);
    cmp_word(rd, 32'h0, "no break-wait after irq");
    pulse(WT);
    tick(2);
    pulse(BRK);
    tick(2);
    axi_read(sys_pkg::BREAK_STATUS_ADDR);
    cmp_word(rd, 32'h2, "break-wait flag");
    pulse(DONE);
    axi_write(sys_pkg::BREAK_STATUS_ADDR, 32'h0);
    axi_read(sys_pkg::BREAK_STATUS_ADDR);
    cmp_word(rd, 32'h0, "break-wait cleared");
    watchdog_disable_option <= 1'b1;
    tick(3);
    cmp_bit(watchdog_enable, 1'b0, "watchdog disabled");
    watchdog_disable_option <= 1'b0;
  endtask
  // Dwell beyond the short count shows whether the counter was held
  task automatic t_stop(input logic short_rec);
    int lo;
    lo = short_rec ? 31 * XT : 4095 * XT;
    short_stop_recovery <= short_rec;
    pulse(STP);
    cmp_bit(irq_mask_clear, 1'b1, "mask cleared by stop");
    tick(1);
    cmp_bit(clock_gen_output, 1'b0, "clock output off");
    cmp_bit(periph_clock_enable, 1'b0, "peripherals stopped");
    tick(300);
    cmp_bit(clock_gen_output, 1'b0, "still stopped");
    module_irq <= 1'b1;
    await(1, 1'b1, 30000);
    module_irq <= 1'b0;
    cmp_range(n, lo, lo + XT + 14, "stop recovery");
    tick(3);
    cmp_bit(clock_gen_output, 1'b1, "clock output back");
  endtask
  task automatic t_causes;
    pulse(WT);
    for (int i = 0; i < 5; i++) begin
      module_irq <= (i == 0);
      pulse(8 + i);
      module_irq <= 1'b0;
      cmp_bit(stack_start, 1'b0, "irq beside reset");
      cmp_bit(system_reset, 1'b1, "internal reset");
      await(2, 1'b0, 4);
      cmp_bit(reset_pin_oe, 1'b0, "pin pulled");
      await(0, 1'b0, 2000);
      axi_read(sys_pkg::RESET_CAUSE_ADDR);
      cmp_word(rd, 32'h1 << (i + 1), "reset cause");
    end
    ext_reset_low <= 1'b1;
    tick(20);
    cmp_bit(system_reset, 1'b1, "pin reset");
    ext_reset_low <= 1'b0;
    await(0, 1'b0, 2000);
    axi_read(sys_pkg::RESET_CAUSE_ADDR);
    cmp_word(rd, 32'h40, "pin cause");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Longest path is the 4096-tick recovery; the ceiling leaves room above it
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      conclude;
    end
  end
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {module_irq, short_stop_recovery, watchdog_disable_option, ext_reset_low, pls} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    tick(1);
    t_reset_map;
    t_break;
    t_break_flag_clear_enable;
    t_wait;
    t_stop(1'b1);
    t_stop(1'b0);
    t_causes;
    conclude;
  end
endmodule
